// ### hw/ubg_map.svh
`ifndef UBG_MAP_SVH
`define UBG_MAP_SVH
// register byte offsets
`define UBG_MODE_OFF 8'h00
`define UBG_CTL_OFF 8'h04
`define UBG_ERR_OFF 8'h08
`define UBG_CLKSEL_OFF 8'h0C
`define UBG_DIV_OFF 8'h10
`define UBG_TXBUF_OFF 8'h14
`define UBG_RXBUF_OFF 8'h18
// mode register fields
`define UBG_POWER_BIT 7
`define UBG_TXEN_BIT 6
`define UBG_RXEN_BIT 5
`define UBG_MERGE_BIT 0
// control register fields
`define UBG_BRK_FLAG_BIT 7
`define UBG_BRK_TRIG_BIT 6
// error status fields
`define UBG_OVR_BIT 0
`define UBG_PAR_BIT 1
`define UBG_FRM_BIT 2
// reset values
`define UBG_DIV_RST 8'hFF
`define UBG_RXBUF_RST 8'hFF
`define UBG_MODE_RST 8'h01
// frame timing, in bit times, then the number of prescaler settings
`define UBG_FRAME_BITS 4'd11
`define UBG_BRK_MIN_BITS 5'd11
`define UBG_NUM_PRESCALE 16
`endif

// ### hw/ubg_pkg.sv
package ubg_pkg;
  typedef enum logic [2:0] {
    UBG_RX_IDLE = 3'b001,
    UBG_RX_START = 3'b010,
    UBG_RX_DATA = 3'b100
  } ubg_rx_st_t;
  typedef enum logic [2:0] {
    UBG_AX_IDLE = 3'b001,
    UBG_AX_WRESP = 3'b010,
    UBG_AX_RRESP = 3'b100
  } ubg_ax_st_t;
  typedef struct packed {
    logic [7:0] mode;
    logic brk_flag;
    logic brk_trig;
    logic [2:0] err;
    logic [3:0] clk_sel;
    logic [7:0] divisor;
    logic [7:0] rx_buffer;
    logic rx_full;
    logic [7:0] tx_buffer;
    logic tx_pending;
    logic tx_busy;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic serial_out;
    logic [7:0] tx_cnt;
    logic tx_half;
    logic [14:0] prescale;
    logic base_tick;
    logic [2:0] sync;
    logic [1:0] filt_smp;
    logic rx_filt;
    logic rx_prev;
    ubg_rx_st_t rx_st;
    logic [7:0] rx_cnt;
    logic rx_half;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_par;
    logic [4:0] low_bits;
    logic rx_done_irq;
    logic rx_err_irq;
    logic tx_done_irq;
    ubg_ax_st_t ax_st;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ubg_state_t;
endpackage

// ### hw/ubg_uart.sv
// Overview of operation
// - merge bit clear: errors on own interrupt; set: via receive-complete interrupt
// - receive line sampled per base tick; filtered input follows two matching samples
// - receive processing lags the external line by two base clocks
// - break receive armed by trigger bit with power and receive enable set
// - stop after eleven or more low bits: complete interrupt, clear trigger and flag
// - break reception suppresses overrun, parity and framing error flags
// - break reception never loads the receive buffer; it keeps FFH
// - break of ten bits or less: no interrupt, mode and flags kept
// - independent 8-bit counters for transmit and receive
// - 4-bit select picks base clock; gated off while power is zero
// - transmit counter cleared while power or transmit enable is zero
// - transmit counter clears when first byte is written
// - continuous transmit clears counter per frame, else keeps counting
// - receive counter cleared when disabled, starts on start bit detection
// - receive counter halts after a full frame until next start bit
// - baud rate is base clock over 2k, k from 8 to 255
// - reading the error status register clears all error flags
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "ubg_map.svh"
module ubg_uart
  import ubg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  output logic serial_out,
  output logic rx_done_irq,
  output logic rx_err_irq,
  output logic tx_done_irq
);
  ubg_state_t q_reg, q_next;
  logic power, tx_en, rx_en, merge;
  logic wr_go, rd_go;
  logic [7:0] wa;
  logic [31:0] wd;
  logic tx_tick, rx_tick, mid_bit;
  logic err_ov, err_pe, err_fe, brk_mode;

  assign power = q_reg.mode[`UBG_POWER_BIT];
  assign tx_en = q_reg.mode[`UBG_TXEN_BIT];
  assign rx_en = q_reg.mode[`UBG_RXEN_BIT];
  assign merge = q_reg.mode[`UBG_MERGE_BIT];
  // handshakes follow the slave state; writes wait for both channels
  assign s_axi_awready = (q_reg.ax_st == UBG_AX_IDLE) && !q_reg.aw_got;
  assign s_axi_wready = (q_reg.ax_st == UBG_AX_IDLE) && !q_reg.w_got;
  assign s_axi_arready = (q_reg.ax_st == UBG_AX_IDLE) && !s_axi_awvalid
    && !q_reg.aw_got && !q_reg.w_got;
  assign s_axi_bvalid = (q_reg.ax_st == UBG_AX_WRESP);
  assign s_axi_rvalid = (q_reg.ax_st == UBG_AX_RRESP);
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_rresp = q_reg.rresp;
  assign s_axi_rdata = q_reg.rdata;
  assign serial_out = q_reg.serial_out;
  assign rx_done_irq = q_reg.rx_done_irq;
  assign rx_err_irq = q_reg.rx_err_irq;
  assign tx_done_irq = q_reg.tx_done_irq;

  always_comb begin
    q_next = q_reg;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wa = q_reg.aw_addr;
    wd = q_reg.w_data;
    err_ov = 1'b0;
    err_pe = 1'b0;
    err_fe = 1'b0;
    q_next.rx_done_irq = 1'b0;
    q_next.rx_err_irq = 1'b0;
    q_next.tx_done_irq = 1'b0;

    // base tick: divide by 2^sel, held off while unpowered
    q_next.prescale = power ? q_reg.prescale + 15'd1 : 15'd0;
    q_next.base_tick = power &&
      ((q_reg.prescale & ((15'd1 << q_reg.clk_sel) - 15'd1)) == 15'd0);

    // three-flop synchroniser, then match detector on base ticks
    q_next.sync = {q_reg.sync[1:0], serial_in};
    if (q_reg.base_tick) begin
      q_next.filt_smp = {q_reg.filt_smp[0], q_reg.sync[2]};
      // agreement of two samples adds two base clocks of lag
      if (q_reg.filt_smp[1] == q_reg.filt_smp[0]) begin
        q_next.rx_filt = q_reg.filt_smp[1];
      end
    end

    // each counter wraps at k, so two wraps make one bit
    // divisor below 8 is not guarded against
    tx_tick = q_reg.base_tick && (q_reg.tx_cnt >= q_reg.divisor - 8'd1);
    rx_tick = q_reg.base_tick && (q_reg.rx_cnt >= q_reg.divisor - 8'd1);
    mid_bit = rx_tick && !q_reg.rx_half;

    // transmit side
    if (!(power && tx_en)) begin
      q_next.tx_cnt = 8'h00;
      q_next.tx_half = 1'b0;
      q_next.tx_busy = 1'b0;
      q_next.tx_pending = 1'b0;
      q_next.serial_out = 1'b1;
    end else begin
      if (q_reg.base_tick) begin
        q_next.tx_cnt = tx_tick ? 8'h00 : q_reg.tx_cnt + 8'd1;
        if (tx_tick) begin
          q_next.tx_half = !q_reg.tx_half;
        end
      end
      if (tx_tick && q_reg.tx_half && q_reg.tx_busy) begin
        q_next.serial_out = q_reg.tx_shift[0];
        q_next.tx_shift = {1'b1, q_reg.tx_shift[9:1]};
        q_next.tx_bits = q_reg.tx_bits - 4'd1;
        if (q_reg.tx_bits == 4'd1) begin
          q_next.tx_busy = 1'b0;
          q_next.tx_done_irq = 1'b1;
        end
      end
      if (!q_next.tx_busy && q_reg.tx_pending) begin
        // counter restarts when a byte enters the shifter
        // with nothing pending it simply runs on
        // even parity sits above the data; the stop bit is the one
        // shifted in behind it, so a 00H byte gives ten low bits
        q_next.tx_shift = {^q_reg.tx_buffer, q_reg.tx_buffer, 1'b0};
        q_next.tx_bits = 4'd11;
        q_next.tx_busy = 1'b1;
        q_next.tx_pending = 1'b0;
        q_next.tx_cnt = 8'h00;
        q_next.tx_half = 1'b0;
      end
    end

    // receive side; byte is 8 data bits with even parity plus stop
    brk_mode = q_reg.brk_trig;
    q_next.rx_prev = q_reg.rx_filt;
    if (!(power && rx_en)) begin
      q_next.rx_st = UBG_RX_IDLE;
      q_next.rx_cnt = 8'h00;
      q_next.rx_half = 1'b0;
    end else begin
      if (q_reg.rx_st != UBG_RX_IDLE && q_reg.base_tick) begin
        q_next.rx_cnt = rx_tick ? 8'h00 : q_reg.rx_cnt + 8'd1;
        if (rx_tick) begin
          q_next.rx_half = !q_reg.rx_half;
        end
      end
      case (q_reg.rx_st)
        UBG_RX_IDLE: begin
          // falling edge starts the counter in either mode
          if (q_reg.rx_prev && !q_reg.rx_filt) begin
            q_next.rx_st = UBG_RX_START;
            q_next.rx_cnt = 8'h00;
            q_next.rx_half = 1'b0;
          end
        end
        UBG_RX_START: begin
          if (mid_bit) begin
            if (q_reg.rx_filt) begin
              q_next.rx_st = UBG_RX_IDLE;
            end else begin
              q_next.rx_st = UBG_RX_DATA;
              q_next.rx_bits = 4'd0;
              q_next.rx_par = 1'b0;
              q_next.low_bits = 5'd1;
              // a break attempt is now under way
              if (brk_mode) begin
                q_next.brk_flag = 1'b1;
              end
            end
          end
        end
        UBG_RX_DATA: begin
          if (mid_bit) begin
            q_next.rx_bits = q_reg.rx_bits + 4'd1;
            if (!q_reg.rx_filt && q_reg.low_bits != 5'd31) begin
              q_next.low_bits = q_reg.low_bits + 5'd1;
            end
            if (q_reg.rx_bits < 4'd8) begin
              q_next.rx_shift = {q_reg.rx_filt, q_reg.rx_shift[7:1]};
            end
            if (q_reg.rx_bits < 4'd9) begin
              q_next.rx_par = q_reg.rx_par ^ q_reg.rx_filt;
            end
            // stop position reached in normal mode, or high seen in break
            if ((!brk_mode && q_reg.rx_bits == `UBG_FRAME_BITS - 4'd2) ||
                (brk_mode && q_reg.rx_filt)) begin
              // counter halts until next start bit
              q_next.rx_st = UBG_RX_IDLE;
              if (brk_mode) begin
                if (q_reg.low_bits >= `UBG_BRK_MIN_BITS) begin
                  q_next.rx_done_irq = 1'b1;
                  q_next.brk_trig = 1'b0;
                  q_next.brk_flag = 1'b0;
                end
                // short break: nothing raised, mode kept
                // no error flags and no buffer load here
              end else begin
                err_ov = q_reg.rx_full;
                err_pe = q_reg.rx_par;
                err_fe = !q_reg.rx_filt;
                if (!q_reg.rx_full) begin
                  q_next.rx_buffer = q_reg.rx_shift;
                  q_next.rx_full = 1'b1;
                end
                if ((err_ov || err_pe || err_fe) && !merge) begin
                  q_next.rx_err_irq = 1'b1;
                end else begin
                  q_next.rx_done_irq = 1'b1;
                end
              end
            end
          end
        end
        default: q_next.rx_st = UBG_RX_IDLE;
      endcase
    end

    // bus slave: capture address and data in either order
    case (q_reg.ax_st)
      UBG_AX_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          q_next.aw_got = 1'b1;
          q_next.aw_addr = s_axi_awaddr;
          wa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          q_next.w_got = 1'b1;
          q_next.w_data = s_axi_wdata;
          wd = s_axi_wdata;
        end
        wr_go = q_next.aw_got && q_next.w_got;
        rd_go = s_axi_arvalid && s_axi_arready;
      end
      UBG_AX_WRESP: begin
        if (s_axi_bready) begin
          q_next.ax_st = UBG_AX_IDLE;
        end
      end
      UBG_AX_RRESP: begin
        if (s_axi_rready) begin
          q_next.ax_st = UBG_AX_IDLE;
        end
      end
      default: q_next.ax_st = UBG_AX_IDLE;
    endcase

    // write decode; only byte lane 0 carries register bits
    if (wr_go) begin
      q_next.aw_got = 1'b0;
      q_next.w_got = 1'b0;
      q_next.ax_st = UBG_AX_WRESP;
      q_next.bresp = 2'b00;
      if (!s_axi_wstrb[0] && q_reg.w_got == 1'b0 && s_axi_wvalid) begin
        q_next.bresp = 2'b00; // empty strobe: accepted, no effect
      end else if (wa == `UBG_MODE_OFF) begin
        q_next.mode = wd[7:0];
      end else if (wa == `UBG_CTL_OFF) begin
        // trigger only arms while powered and receiving
        if (power && rx_en) begin
          q_next.brk_trig = wd[`UBG_BRK_TRIG_BIT];
        end
      end else if (wa == `UBG_CLKSEL_OFF) begin
        q_next.clk_sel = wd[3:0];
      end else if (wa == `UBG_DIV_OFF) begin
        q_next.divisor = wd[7:0];
      end else if (wa == `UBG_TXBUF_OFF) begin
        q_next.tx_buffer = wd[7:0];
        q_next.tx_pending = power && tx_en;
      end else if (wa == `UBG_ERR_OFF || wa == `UBG_RXBUF_OFF) begin
        q_next.bresp = 2'b00; // read-only, write ignored
      end else begin
        q_next.bresp = 2'b10;
      end
    end

    // read decode
    if (rd_go) begin
      q_next.ax_st = UBG_AX_RRESP;
      q_next.rdata = 32'h0000_0000;
      q_next.rresp = 2'b00;
      if (s_axi_araddr == `UBG_MODE_OFF) begin
        q_next.rdata[7:0] = q_reg.mode;
      end else if (s_axi_araddr == `UBG_CTL_OFF) begin
        q_next.rdata[`UBG_BRK_FLAG_BIT] = q_reg.brk_flag;
        q_next.rdata[`UBG_BRK_TRIG_BIT] = q_reg.brk_trig;
      end else if (s_axi_araddr == `UBG_ERR_OFF) begin
        q_next.rdata[2:0] = q_reg.err;
        q_next.err = 3'b000;
      end else if (s_axi_araddr == `UBG_CLKSEL_OFF) begin
        q_next.rdata[3:0] = q_reg.clk_sel;
      end else if (s_axi_araddr == `UBG_DIV_OFF) begin
        q_next.rdata[7:0] = q_reg.divisor;
      end else if (s_axi_araddr == `UBG_TXBUF_OFF) begin
        q_next.rdata[7:0] = q_reg.tx_buffer;
      end else if (s_axi_araddr == `UBG_RXBUF_OFF) begin
        q_next.rdata[7:0] = q_reg.rx_buffer;
        q_next.rx_full = 1'b0;
      end else begin
        q_next.rresp = 2'b10;
      end
    end

    // error set wins over the read clear in the same cycle
    if (err_ov) q_next.err[`UBG_OVR_BIT] = 1'b1;
    if (err_pe) q_next.err[`UBG_PAR_BIT] = 1'b1;
    if (err_fe) q_next.err[`UBG_FRM_BIT] = 1'b1;
    // break flag never outlives the trigger that armed it
    if (!q_next.brk_trig) q_next.brk_flag = 1'b0;
  end

  // one register for the whole state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_reg <= '0;
      q_reg.mode <= `UBG_MODE_RST;
      q_reg.divisor <= `UBG_DIV_RST;
      q_reg.rx_buffer <= `UBG_RXBUF_RST;
      q_reg.serial_out <= 1'b1;
      q_reg.sync <= 3'b111;
      q_reg.filt_smp <= 2'b11;
      q_reg.rx_filt <= 1'b1;
      q_reg.rx_prev <= 1'b1;
      q_reg.tx_shift <= 10'h3FF;
      q_reg.rx_st <= UBG_RX_IDLE;
      q_reg.ax_st <= UBG_AX_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule

// ### tb/ubg_uart_asserts.sv
`include "ubg_map.svh"
module ubg_uart_asserts (
  input logic sys_clk,
  input logic rst,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic serial_out,
  input logic rx_done_irq,
  input logic rx_err_irq,
  input logic tx_done_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] mode_q;
  logic wr_mode;
  // mirror of the mode register; assumes address and data taken together
  assign wr_mode = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == `UBG_MODE_OFF;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= `UBG_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= s_axi_wdata[7:0];
    end
  end
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  busy_refuse_a: assert property (s_axi_bvalid || s_axi_rvalid
    |-> !s_axi_awready && !s_axi_arready) else $error("request taken busy");
  irq_pulse_a: assert property (rx_done_irq |=> !rx_done_irq)
    else $error("receive done pulse too long");
  err_pulse_a: assert property (rx_err_irq |=> !rx_err_irq)
    else $error("error pulse too long");
  tx_pulse_a: assert property (tx_done_irq |=> !tx_done_irq)
    else $error("transmit done pulse too long");
  merge_route_a: assert property (
    mode_q[0] [*3] |-> !rx_err_irq) else $error("error irq while merged");
  tx_gate_a: assert property (
    !(mode_q[7] && mode_q[6]) [*3] |-> serial_out && !tx_done_irq)
    else $error("transmit active while disabled");
  rx_gate_a: assert property (
    !(mode_q[7] && mode_q[5]) [*3] |-> !rx_done_irq && !rx_err_irq)
    else $error("receive irq while disabled");
  cover property (rx_done_irq);
  cover property (rx_err_irq);
  cover property (tx_done_irq);
endmodule
bind ubg_uart ubg_uart_asserts chk_i (.*);

// ### tb/ubg_node.sv
module ubg_node #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_byte = 8'h00;
  int got_cnt = 0;
  int low_len = 0;
  int run = 0;
  initial line_out = 1'b1;
  // hold one level for whole bit times
  task automatic hold_lvl(input logic v, input int n);
    line_out <= v;
    repeat (n * BIT) @(posedge clk);
  endtask
  // start, eight data lsb first, even parity, stop
  task automatic send(input logic [7:0] d, input logic bad_par);
    hold_lvl(1'b0, 1);
    for (int i = 0; i < 8; i++) hold_lvl(d[i], 1);
    hold_lvl(^d ^ bad_par, 1);
    hold_lvl(1'b1, 2);
  endtask
  // stretched low run, as a scaled divisor would give
  task automatic brk(input int n);
    hold_lvl(1'b0, n);
    hold_lvl(1'b1, 2);
  endtask
  // one-clock dip: too short to pass a two-sample filter
  task automatic glitch();
    line_out <= 1'b0;
    @(posedge clk);
    hold_lvl(1'b1, 1);
  endtask
  // length of the latest low run on the line from the block
  always @(posedge clk) begin
    if (line_in === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) low_len <= run;
      run <= 0;
    end
  end
  // decode frames from the block by mid-bit sampling
  always begin
    @(posedge clk iff line_in === 1'b0);
    repeat (BIT + BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      got_byte[i] = line_in;
      repeat (BIT) @(posedge clk);
    end
    repeat (BIT) @(posedge clk);
    got_cnt++;
  end
endmodule

// ### tb/ubg_uart_tb.sv
`include "ubg_map.svh"
module ubg_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16; // divisor 8 on an undivided base clock
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_in, serial_out;
  logic rx_done_irq, rx_err_irq, tx_done_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] last_bresp = 2'b00;
  int err_count = 0, n_tests = 0, n_done = 0, n_err = 0, n_tx = 0;
  ubg_uart dut (.*);
  ubg_node #(.BIT(BIT)) node (.clk(sys_clk), .line_in(serial_out),
    .line_out(serial_in));
  always #5 sys_clk = ~sys_clk;
  // interrupt pulses counted as they pass
  always @(posedge sys_clk) begin
    if (rx_done_irq === 1'b1) n_done++;
    if (rx_err_irq === 1'b1) n_err++;
    if (tx_done_irq === 1'b1) n_tx++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // handshakes judged at the rising edge, released right after it;
  // one idle edge at the end keeps ready from toggling in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic b_hit;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      b_hit = s_axi_bvalid && s_axi_bready;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!b_hit);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic r_hit;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      r_hit = s_axi_rvalid && s_axi_rready;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!r_hit);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic wait_bits(input int n);
    repeat (n * BIT) @(posedge sys_clk);
  endtask
  // reset values, then an address nothing answers to
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc(`UBG_MODE_OFF, 32'h0000_0001);
    rc(`UBG_DIV_OFF, 32'h0000_00FF);
    rc(`UBG_RXBUF_OFF, 32'h0000_00FF);
    rd(8'h1C, d, r);
    chk({30'h0, r}, 32'h0000_0002);
    wr(8'h1C, 8'h00);
    chk({30'h0, last_bresp}, 32'h0000_0002);
  endtask
  // a short break is ignored, a long one raises only the complete interrupt and ends break mode
  task automatic t_break();
    int d0, e0;
    wr(`UBG_CTL_OFF, 8'h40);
    d0 = n_done;
    e0 = n_err;
    node.send(8'h00, 1'b0);
    wait_bits(2);
    chk(n_done - d0 + n_err - e0, 0);
    rc(`UBG_CTL_OFF, 32'h0000_00C0);
    node.brk(13);
    wait_bits(2);
    chk(n_done - d0, 1);
    chk(n_err - e0, 0);
    rc(`UBG_CTL_OFF, 32'h0000_0000);
    rc(`UBG_ERR_OFF, 32'h0000_0000);
    rc(`UBG_RXBUF_OFF, 32'h0000_00FF);
  endtask
  // filtered dip, good frame, then parity errors split and merged
  task automatic t_rx();
    int d0, e0;
    d0 = n_done;
    e0 = n_err;
    node.glitch();
    node.send(8'h3C, 1'b0);
    wait_bits(1);
    rc(`UBG_RXBUF_OFF, 32'h0000_003C);
    node.send(8'h5A, 1'b1);
    wait_bits(1);
    chk(n_err - e0, 1);
    chk(n_done - d0, 1);
    rc(`UBG_ERR_OFF, 32'h0000_0002);
    rc(`UBG_ERR_OFF, 32'h0000_0000);
    wr(`UBG_MODE_OFF, 8'hE1);
    node.send(8'h5A, 1'b1);
    wait_bits(1);
    chk(n_err - e0, 1);
    chk(n_done - d0, 2);
  endtask
  // one byte out: seven low data bits give the bit time; then a break
  // byte with the base clock halved stretches ten low bits to twenty
  task automatic t_tx();
    int t0, c0;
    t0 = n_tx;
    c0 = node.got_cnt;
    wr(`UBG_TXBUF_OFF, 8'h01);
    wait_bits(14);
    chk(node.got_cnt - c0, 1);
    chk(node.got_byte, 8'h01);
    chk(node.low_len, 7 * BIT);
    chk(n_tx - t0, 1);
    wr(`UBG_CLKSEL_OFF, 8'h01);
    wr(`UBG_TXBUF_OFF, 8'h00);
    wait_bits(26);
    chk(node.low_len, 20 * BIT);
    chk(n_tx - t0, 2);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    wr(`UBG_CLKSEL_OFF, 8'h00);
    wr(`UBG_DIV_OFF, 8'h08);
    wr(`UBG_MODE_OFF, 8'hE0);
    t_break();
    t_rx();
    t_tx();
    give_verdict();
  end
endmodule
